// file: core/ofrf_top.sv
// Functional notes
// RULE_01: Each event has its own programmed filter register.
// RULE_02: Bits 15:0 select request types.
// RULE_03: Bits 29:16 select supplier attributes.
// RULE_04: Bits 37:30 select snoop outcomes.
// RULE_05: Bit 0 selects demand data loads.
// RULE_06: Bit 1 selects demand ownership reads.
// RULE_07: Bit 2 selects instruction reads and prefetches.
// RULE_08: Bit 15 misc; bits 14:3 reserved.
// RULE_09: Bit 16 matches any response.
// RULE_10: Bit 17 matches unknown supplier.
// RULE_11: Bits 18-20 match last-level M/E/S hits.
// RULE_12: Bit 22 matches fourth-level cache hits.
// RULE_13: Bit 30 matches super line hits.
// RULE_14: Bit 31 matches responses without snoop detail.
// RULE_15: Bit 32 matches requests needing no snoop.
// RULE_16: Bit 33 matches snoops missing every cache.
// RULE_17: Bit 34 matches snoop hits without forwarding.
// RULE_18: Bit 35 matches clean remote forwards.
// RULE_19: Bit 36 matches snoops hitting modified lines.
// RULE_20: Bit 37 matches non-DRAM system addresses.
// RULE_21: Count needs request and attribute match.
// RULE_22: Software writes zero to reserved bits.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module ofrf_top #(
  parameter int NUM_EVENTS = 4,
  parameter bit L4_PRESENT = 1'b1,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ofrf_pkg::ofrf_txn_t txn,
  output logic [NUM_EVENTS-1:0] count_pulse
);
  import ofrf_pkg::*;

  localparam int IW = (NUM_EVENTS > 1) ? $clog2(NUM_EVENTS) : 1;
  localparam int CW = AW - OFRF_CFG_STRIDE_LOG2;
  localparam logic [OFRF_CFG_W-1:0] WMASK =
    L4_PRESENT ? OFRF_CFG_WMASK : (OFRF_CFG_WMASK & ~OFRF_CFG_L4_MASK);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  wire logic [CW-1:0] cfg_idx;
  wire logic [IW-1:0] cfg_sel;
  wire logic [AW-1:0] hit_cnt_rel;
  wire logic [IW-1:0] hit_sel;
  wire logic aligned;
  wire logic is_cfg;
  wire logic is_ctrl;
  wire logic is_stat;
  wire logic is_txn_cnt;
  wire logic is_last_req;
  wire logic is_last_attr;
  wire logic is_hit_cnt;
  wire logic mapped;
  wire logic setup;
  wire logic acc_fire;
  wire logic wr_fire;

  assign cfg_idx = paddr[AW-1:OFRF_CFG_STRIDE_LOG2];
  assign cfg_sel = cfg_idx[IW-1:0];
  assign hit_cnt_rel = paddr - AW'(OFRF_HIT_CNT_BASE);
  assign hit_sel = hit_cnt_rel[IW+1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign is_cfg = aligned && (paddr >= AW'(OFRF_CFG_BASE)) && (cfg_idx < CW'(NUM_EVENTS));
  assign is_ctrl = (paddr == AW'(OFRF_CTRL_OFS));
  assign is_stat = (paddr == AW'(OFRF_STAT_OFS));
  assign is_txn_cnt = (paddr == AW'(OFRF_TXN_CNT_OFS));
  assign is_last_req = (paddr == AW'(OFRF_LAST_REQ_OFS));
  assign is_last_attr = (paddr == AW'(OFRF_LAST_ATTR_OFS));
  assign is_hit_cnt = aligned && (paddr >= AW'(OFRF_HIT_CNT_BASE)) &&
                      (hit_cnt_rel[AW-1:2] < (AW-2)'(NUM_EVENTS));
  assign mapped = is_cfg | is_ctrl | is_stat | is_txn_cnt | is_last_req |
                  is_last_attr | is_hit_cnt;

  // Setup cycle prepares the answer; the access phase then completes in one cycle
  assign setup = psel & ~penable;
  assign acc_fire = psel & penable & pready;
  // Unmapped writes are dropped and flagged with pslverr
  assign wr_fire = acc_fire & pwrite & mapped;

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  logic enable_q;
  logic enable_d;
  logic clear_q;
  logic clear_d;
  wire logic [31:0] ctrl_word;
  wire logic [31:0] ctrl_merged;

  assign ctrl_word = {30'h0, 1'b0, enable_q};
  assign ctrl_merged = merge_bytes(ctrl_word, pwdata, pstrb);
  assign enable_d = (wr_fire && is_ctrl) ? ctrl_merged[OFRF_CTRL_ENABLE_BIT] : enable_q;
  // Clear request is a self-clearing one-cycle strobe
  assign clear_d = wr_fire && is_ctrl && ctrl_merged[OFRF_CTRL_CLEAR_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_q <= OFRF_CTRL_ENABLE_RESET;
      clear_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      clear_q <= clear_d;
    end
  end

  // ------------------------------------------------------------------
  // Per-event filter registers and matchers
  // ------------------------------------------------------------------
  logic [OFRF_CFG_W-1:0] cfg_q [NUM_EVENTS];
  logic [31:0] hit_cnt_q [NUM_EVENTS];
  wire ofrf_match_t match [NUM_EVENTS];
  wire logic [NUM_EVENTS-1:0] hit_vec;

  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_evt
    wire logic sel;
    wire logic [31:0] lo_merged;
    wire logic [31:0] hi_merged;
    wire logic [OFRF_CFG_W-1:0] cfg_wr;
    wire logic [OFRF_CFG_W-1:0] cfg_d;
    wire logic [31:0] hit_cnt_d;

    assign sel = wr_fire && is_cfg && (cfg_idx == CW'(i));
    assign lo_merged = merge_bytes(cfg_q[i][31:0], pwdata, pstrb);
    assign hi_merged = merge_bytes({26'h0, cfg_q[i][37:32]}, pwdata, pstrb);
    // Low word holds bits 31:0, high word bits 37:32; reserved bits are forced to zero
    assign cfg_wr = paddr[2] ? {hi_merged[5:0], cfg_q[i][31:0]} : {cfg_q[i][37:32], lo_merged};
    assign cfg_d = sel ? (cfg_wr & WMASK) : cfg_q[i]; // [RULE_01] [RULE_08] [RULE_22]

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cfg_q[i] <= OFRF_CFG_RESET;
      end else begin
        cfg_q[i] <= cfg_d;
      end
    end

    // Each event is judged against its own register only
    ofrf_match u_match (
      .cfg(cfg_q[i]),
      .txn(txn),
      .result(match[i])
    ); // [RULE_01]

    assign hit_vec[i] = match[i].hit & enable_q; // [RULE_21]
    // A hit in the clear cycle still counts: counter restarts at one
    assign hit_cnt_d = clear_q ? {31'h0, hit_vec[i]} :
                       (hit_vec[i] ? sat_inc(hit_cnt_q[i]) : hit_cnt_q[i]);

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        hit_cnt_q[i] <= OFRF_WORD_RESET;
      end else begin
        hit_cnt_q[i] <= hit_cnt_d;
      end
    end
  end

  // ------------------------------------------------------------------
  // Event outputs and observed-transaction state
  // ------------------------------------------------------------------
  logic [NUM_EVENTS-1:0] last_hit_q;
  logic [31:0] txn_cnt_q;
  logic [15:0] last_req_q;
  logic [OFRF_ATTR_W-1:0] last_attr_q;
  wire logic txn_seen;
  wire logic [31:0] txn_cnt_d;

  assign txn_seen = txn.valid & enable_q;
  assign txn_cnt_d = clear_q ? {31'h0, txn_seen} :
                     (txn_seen ? sat_inc(txn_cnt_q) : txn_cnt_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_pulse <= '0;
      last_hit_q <= '0;
      txn_cnt_q <= OFRF_WORD_RESET;
      last_req_q <= 16'h0000;
      last_attr_q <= '0;
    end else begin
      count_pulse <= hit_vec; // [RULE_21]
      txn_cnt_q <= txn_cnt_d;
      if (txn_seen) begin
        last_hit_q <= hit_vec;
        last_req_q <= txn.req;
        last_attr_q <= txn.attr;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  wire logic [OFRF_CFG_W-1:0] rd_cfg;
  wire logic [31:0] rd_cfg_word;
  wire logic [31:0] rd_word;

  assign rd_cfg = cfg_q[cfg_sel];
  assign rd_cfg_word = paddr[2] ? {26'h0, rd_cfg[37:32]} : rd_cfg[31:0];
  assign rd_word =
    is_cfg ? rd_cfg_word :
    is_ctrl ? ctrl_word :
    is_stat ? 32'(last_hit_q) :
    is_txn_cnt ? txn_cnt_q :
    is_last_req ? {16'h0000, last_req_q} :
    is_last_attr ? {11'h000, last_attr_q} :
    is_hit_cnt ? hit_cnt_q[hit_sel] :
    32'h0000_0000;

  // ------------------------------------------------------------------
  // APB response flops
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= OFRF_WORD_RESET;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite && mapped) ? rd_word : 32'h0000_0000;
    end
  end

endmodule

// file: core/ofrf_pkg.sv
package ofrf_pkg;

  // ------------------------------------------------------------------
  // Configuration word layout
  // ------------------------------------------------------------------
  localparam int OFRF_CFG_W = 38;
  localparam int OFRF_REQ_LSB = 0;
  localparam int OFRF_REQ_MSB = 15;
  localparam int OFRF_SUP_LSB = 16;
  localparam int OFRF_SUP_MSB = 29;
  localparam int OFRF_SNP_LSB = 30;
  localparam int OFRF_SNP_MSB = 37;
  localparam int OFRF_ATTR_LSB = 17;
  localparam int OFRF_ATTR_W = 21;

  // Request-type bits
  localparam int OFRF_BIT_DEMAND_LOAD_SELECT = 0;
  localparam int OFRF_BIT_DEMAND_OWNERSHIP_READ_SELECT = 1;
  localparam int OFRF_BIT_DEMAND_INSTRUCTION_READ_SELECT = 2;
  localparam int OFRF_BIT_MISC_REQUEST_SELECT = 15;
  // Supplier bits
  localparam int OFRF_BIT_ANY_RESPONSE = 16;
  localparam int OFRF_BIT_SUPPLIER_UNKNOWN = 17;
  localparam int OFRF_BIT_LLC_HIT_MODIFIED = 18;
  localparam int OFRF_BIT_LLC_HIT_EXCLUSIVE = 19;
  localparam int OFRF_BIT_LLC_HIT_SHARED = 20;
  localparam int OFRF_BIT_FOURTH_LEVEL_CACHE_HIT = 22;
  localparam int OFRF_BIT_LOCAL_DRAM = 26;
  // Snoop bits
  localparam int OFRF_BIT_SUPER_LINE_HIT = 30;
  localparam int OFRF_BIT_SNOOP_NO_DETAIL = 31;
  localparam int OFRF_BIT_SNOOP_NOT_NEEDED = 32;
  localparam int OFRF_BIT_SNOOP_MISS = 33;
  localparam int OFRF_BIT_SNOOP_HIT_WITHOUT_FORWARD = 34;
  localparam int OFRF_BIT_SNOOP_HIT_FORWARDED = 35;
  localparam int OFRF_BIT_SNOOP_HIT_MODIFIED_LINE = 36;
  localparam int OFRF_BIT_SNOOP_NON_DRAM = 37;

  // Writable bits; reserved bits 3-14, 21, 23-25, 27-29 stay zero
  localparam logic [OFRF_CFG_W-1:0] OFRF_CFG_WMASK = 38'h3F_C45F_8007;
  // Bits that only mean something with a fourth-level cache
  localparam logic [OFRF_CFG_W-1:0] OFRF_CFG_L4_MASK = 38'h00_4040_0000;
  localparam logic [OFRF_CFG_W-1:0] OFRF_CFG_RESET = 38'h00_0000_0000;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [11:0] OFRF_CFG_BASE = 12'h000;
  localparam int OFRF_CFG_STRIDE_LOG2 = 3;
  localparam logic [11:0] OFRF_CTRL_OFS = 12'h080;
  localparam logic [11:0] OFRF_STAT_OFS = 12'h100;
  localparam logic [11:0] OFRF_TXN_CNT_OFS = 12'h104;
  localparam logic [11:0] OFRF_LAST_REQ_OFS = 12'h108;
  localparam logic [11:0] OFRF_LAST_ATTR_OFS = 12'h10C;
  localparam logic [11:0] OFRF_HIT_CNT_BASE = 12'h180;

  localparam int OFRF_CTRL_ENABLE_BIT = 0;
  localparam int OFRF_CTRL_CLEAR_BIT = 1;
  localparam logic OFRF_CTRL_ENABLE_RESET = 1'b1;
  localparam logic [31:0] OFRF_WORD_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Completed off-core transaction
  // ------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [OFRF_ATTR_W-1:0] attr;
    logic [15:0] req;
  } ofrf_txn_t;

  typedef struct packed {
    logic req_hit;
    logic attr_hit;
    logic hit;
  } ofrf_match_t;

endpackage

// file: core/ofrf_match.sv
`timescale 1ns/1ps

module ofrf_match (
  input wire logic [ofrf_pkg::OFRF_CFG_W-1:0] cfg,
  input wire ofrf_pkg::ofrf_txn_t txn,
  output ofrf_pkg::ofrf_match_t result
);
  import ofrf_pkg::*;

  // ------------------------------------------------------------------
  // Field split
  // ------------------------------------------------------------------
  wire logic [15:0] req_sel;
  wire logic any_sel;
  wire logic [OFRF_ATTR_W-1:0] attr_sel;
  wire logic req_hit;
  wire logic attr_hit;

  assign req_sel = cfg[OFRF_REQ_MSB:OFRF_REQ_LSB]; // [RULE_02]
  assign any_sel = cfg[OFRF_BIT_ANY_RESPONSE];
  assign attr_sel = cfg[OFRF_SNP_MSB:OFRF_ATTR_LSB]; // [RULE_03] [RULE_04]

  // ------------------------------------------------------------------
  // Matching
  // ------------------------------------------------------------------
  // Request class bits: demand load, ownership read, instruction read, misc
  assign req_hit = |(req_sel & txn.req); // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
  // Supplier and snoop attributes; the catch-all bit accepts any response
  assign attr_hit = any_sel | (|(attr_sel & txn.attr)); // [RULE_09] [RULE_10] [RULE_11] [RULE_12] [RULE_13] [RULE_14] [RULE_15] [RULE_16] [RULE_17] [RULE_18] [RULE_19] [RULE_20]

  assign result.req_hit = req_hit;
  assign result.attr_hit = attr_hit;
  assign result.hit = txn.valid & req_hit & attr_hit; // [RULE_21]

endmodule

// file: test/ofrf_top_assertions.sv
`timescale 1ns/1ps

module ofrf_top_assertions #(
  parameter int NUM_EVENTS = 4,
  parameter bit L4_PRESENT = 1'b1,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ofrf_pkg::ofrf_txn_t txn,
  input wire logic [NUM_EVENTS-1:0] count_pulse
);
  import ofrf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------
  // Register bus
  // ---------------------------------------------
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("answer outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_mis; psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr; endproperty
  a_mis: assert property (p_mis) else $error("misaligned access not refused");
  property p_lo;
    pready && !pwrite && paddr < AW'(8 * NUM_EVENTS) && paddr[2:0] == 3'h0
      |-> (prdata & ~OFRF_CFG_WMASK[31:0]) == 32'h0;
  endproperty
  a_lo: assert property (p_lo) else $error("reserved bits read nonzero");
  property p_hi;
    pready && !pwrite && paddr < AW'(8 * NUM_EVENTS) && paddr[2:0] == 3'h4
      |-> prdata[31:6] == 26'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("high word above bit 37 nonzero");
  // ---------------------------------------------
  // Filter; covers for bus writes, error answers and filter hits
  // ---------------------------------------------
  property p_idle; !txn.valid |=> count_pulse == '0; endproperty
  a_idle: assert property (p_idle) else $error("pulse without transaction");
  property p_noreq; txn.valid && txn.req == 16'h0 |=> count_pulse == '0; endproperty
  a_noreq: assert property (p_noreq) else $error("pulse without request");
  c_wr: cover property (psel && penable && pready && pwrite);
  c_serr: cover property (pready && pslverr);
  c_hit: cover property (txn.valid ##1 count_pulse != '0);
endmodule

bind ofrf_top ofrf_top_assertions #(.NUM_EVENTS(NUM_EVENTS), .L4_PRESENT(L4_PRESENT),
  .AW(AW)) u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txn(txn), .count_pulse(count_pulse));

// file: test/tb_top.sv
`timescale 1ns/1ps

`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
  end \
end

module tb_top;
  import ofrf_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF, count_pulse, p;
  logic pready, pslverr;
  ofrf_txn_t txn = '0;
  int err_total = 0, comparisons = 0, cyc = 0;
  int rq[4] = '{0, 1, 2, 15};
  int ab[14] = '{17, 18, 19, 20, 22, 26, 30, 31, 32, 33, 34, 35, 36, 37};

  ofrf_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txn(txn), .count_pulse(count_pulse));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("compares %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 20000) begin
        err_total++;
        test_done();
      end
    end
  end

  // ---------------------------------------------
  // Bus and transaction drivers
  // ---------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Answer is taken at the rising edge that sees pready; without pready only the timeout ends the wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setcfg(input int i, input logic [37:0] c);
    apb(1'b1, 12'(8 * i), c[31:0]);
    apb(1'b1, 12'(8 * i + 4), {26'h0, c[37:32]});
  endtask

  task automatic tx(input logic [15:0] q, input logic [20:0] a);
    @(posedge clk);
    txn <= '{1'b1, a, q};
    @(posedge clk);
    txn.valid <= 1'b0;
    @(negedge clk);
    p = count_pulse;
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset();
    `CHK(count_pulse, 4'h0)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b0, 12'h080, 32'h0);
    `CHK({e, r}, 33'h0_0000_0001)
  endtask

  task automatic t_layout();
    setcfg(0, 38'h3F_FFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'hC45F_8007)
    apb(1'b0, 12'h004, 32'h0);
    `CHK(r, 32'h3F)
  endtask

  task automatic t_bits();
    logic [37:0] c;
    for (int i = 0; i < 14; i++) begin
      c = (38'h1 << rq[i % 4]) | (38'h1 << ab[i]);
      setcfg(0, c);
      tx(16'h1 << rq[i % 4], 21'h1 << (ab[i] - 17));
      `CHK(p, 4'h1)
      tx(~(16'h1 << rq[i % 4]), ~(21'h1 << (ab[i] - 17)));
      `CHK(p, 4'h0)
      tx(16'h1 << rq[i % 4], ~(21'h1 << (ab[i] - 17)));
      `CHK(p, 4'h0)
    end
  endtask

  task automatic t_events();
    for (int i = 0; i < 4; i++) begin
      setcfg(i, (38'h1 << rq[i]) | 38'h1_0000);
    end
    apb(1'b1, 12'h080, 32'h3);
    for (int j = 0; j < 4; j++) begin
      tx(16'h1 << rq[j], 21'h0);
      `CHK(p, 4'h1 << j)
    end
    tx(16'h1 << rq[2], 21'h1F_FFFF);
    `CHK(p, 4'h4)
    apb(1'b0, 12'h100, 32'h0);
    `CHK(r, 32'h4)
    apb(1'b0, 12'h108, 32'h0);
    `CHK(r, 32'h4)
    tx(16'h0, 21'h1F_FFFF);
    `CHK(p, 4'h0)
    apb(1'b0, 12'h180, 32'h0);
    `CHK(r, 32'h1)
    apb(1'b0, 12'h188, 32'h0);
    `CHK(r, 32'h2)
    apb(1'b1, 12'h080, 32'h0);
    tx(16'h1 << rq[2], 21'h0);
    `CHK(p, 4'h0)
    apb(1'b0, 12'h188, 32'h0);
    `CHK(r, 32'h2)
    apb(1'b0, 12'h104, 32'h0);
    `CHK(r, 32'h6)
    apb(1'b0, 12'h10C, 32'h0);
    `CHK(r, 32'h1F_FFFF)
    apb(1'b1, 12'h080, 32'h1);
  endtask

  task automatic t_refuse();
    apb(1'b0, 12'h200, 32'h0);
    `CHK({e, r}, 33'h1_0000_0000)
    apb(1'b1, 12'h002, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h0001_0001)
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    `CHK(r, 32'h0001_0007)
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_layout();
    t_bits();
    t_events();
    t_refuse();
    test_done();
  end
endmodule
